/* src/spt_timer_defs.vh */
/*
  Constants of the split timer pair: register offsets, field positions,
  reset values, mode codes and the default prescaler ratio.
  Assumes it is included by bare name and that nothing else defines these names.
*/
`ifndef SPT_TIMER_DEFS_VH
`define SPT_TIMER_DEFS_VH

// register offsets on the 4-bit address port
`define SPT_ADDR_W            4
`define SPT_OFF_CONTROL       4'h0
`define SPT_OFF_MODE          4'h1
`define SPT_OFF_CLKSEL        4'h2
`define SPT_OFF_T0_LOW        4'h3
`define SPT_OFF_T0_HIGH       4'h4
`define SPT_OFF_T1_LOW        4'h5
`define SPT_OFF_T1_HIGH       4'h6

// timer_control_reg fields
`define SPT_CTL_T1_FLAG       7
`define SPT_CTL_T1_RUN        6
`define SPT_CTL_T0_FLAG       5
`define SPT_CTL_T0_RUN        4

// timer_mode_reg fields
`define SPT_MOD_T1_GATE       7
`define SPT_MOD_T1_CSEL       6
`define SPT_MOD_T1_MODE_HI    5
`define SPT_MOD_T1_MODE_LO    4
`define SPT_MOD_T0_GATE       3
`define SPT_MOD_T0_CSEL       2
`define SPT_MOD_T0_MODE_HI    1
`define SPT_MOD_T0_MODE_LO    0

// clock select register fields
`define SPT_CKS_T0_LOW_PRE    0
`define SPT_CKS_T1_PRE        1
`define SPT_CKS_T0_HIGH_PRE   2
`define SPT_CKS_USED_W        3

// reset values
`define SPT_RST_CONTROL       8'h00
`define SPT_RST_MODE          8'h00
`define SPT_RST_CLKSEL        3'h0
`define SPT_RST_COUNT         8'h00

// mode codes
`define SPT_MODE_13BIT        2'h0
`define SPT_MODE_16BIT        2'h1
`define SPT_MODE_RELOAD       2'h2
`define SPT_MODE_SPLIT        2'h3

// wrap values
`define SPT_TOP_FULL          8'hFF
`define SPT_TOP_5BIT          8'h1F

// prescaled clock ratio in system clocks
`define SPT_PRESCALE_DIV      12

`endif

/* src/spt_count_cell.v */
/*
  One 8-bit up-counter byte with a programmable wrap value, optional reload
  on wrap and a software load port.
  Assumes a single clock, a synchronous active-low reset and a clock enable.
*/
module spt_count_cell #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             inc,
  input  wire [WIDTH-1:0] top,
  input  wire             reload_en,
  input  wire [WIDTH-1:0] reload_val,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output wire [WIDTH-1:0] count,
  output wire             carry
);

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  // carry marks the wrap cycle so the flag sets on the same edge
  assign carry = inc & (count_q == top);
  assign count = count_q;

  always @* begin
    count_d = count_q;
    if (wr_en) begin
      count_d = wr_data;
    end else if (carry) begin
      count_d = reload_en ? reload_val : {WIDTH{1'b0}};
    end else if (inc) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      count_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      count_q <= count_d;
    end
  end

endmodule

/* src/spt_timer_top.v */
/*
  Timer 0 / Timer 1 pair with the split mode of Timer 0, register port,
  external count inputs, gate inputs and the Timer 1 overflow pulse.
  Assumes one system clock, a register master that keeps strobes one cycle
  long and never both at once, and asynchronous external pins.
*/
`include "spt_timer_defs.vh"
module spt_timer_top #(
  parameter PRESCALE_DIV = `SPT_PRESCALE_DIV
) (
  input  wire       CLK_SYS,
  input  wire       RST_N,
  input  wire       CE,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output wire [7:0] RDATA,
  input  wire       T0_PIN,
  input  wire       T1_PIN,
  input  wire       T0_GATE_SELECT_PIN,
  input  wire       GATE1_PIN,
  output wire       T0_IRQ,
  output wire       T1_IRQ,
  output wire       T1_OVF_PULSE
);

  // register state
  reg        t0_run_bit_q;
  reg        t1_run_bit_q;
  reg        t0_overflow_flag_q;
  reg        t0_overflow_flag_d;
  reg        t1_overflow_flag_q;
  reg        t1_overflow_flag_d;
  reg [7:0]  timer_mode_reg_q;
  reg [`SPT_CKS_USED_W-1:0] clksel_q;
  reg [7:0]  rdata_q;
  reg [7:0]  rdata_d;
  reg        t1_pulse_q;

  // pin synchronisers and edge history
  reg [1:0]  t0_pin_sync_q;
  reg [1:0]  t1_pin_sync_q;
  reg [1:0]  t0_gate_select_sync_q;
  reg [1:0]  gate1_sync_q;
  reg        t0_pin_last_q;
  reg        t1_pin_last_q;

  // prescaler
  localparam PRE_W = 8;
  reg [PRE_W-1:0] pre_cnt_q;
  wire            pre_tick;

  // decoded controls
  wire [1:0] t0_mode;
  wire [1:0] t1_mode;
  wire       t0_split;
  wire       t0_counter_select;
  wire       t0_gate_select;
  wire       t1_counter_select;
  wire       t1_gate_select;
  wire       t0_ext_fall;
  wire       t1_ext_fall;

  // count byte wiring
  wire [7:0] t0_low_count;
  wire [7:0] t0_high_count;
  wire [7:0] t1_low_count;
  wire [7:0] t1_high_count;
  wire       t0_low_carry;
  wire       t0_high_carry;
  wire       t1_low_carry;
  wire       t1_high_carry;

  reg        t0_tick;
  reg        t0_run;
  reg        t0_low_inc;
  reg        t0_high_inc;
  reg [7:0]  t0_low_top;
  reg        t0_low_reload;
  reg        t0_ovf;
  reg        t0h_split_ovf;
  reg        t1_tick;
  reg        t1_run;
  reg        t1_low_inc;
  reg        t1_high_inc;
  reg [7:0]  t1_low_top;
  reg        t1_low_reload;
  reg        t1_ovf;
  reg        t1_flag_set;

  wire       wr_control;
  wire       wr_mode;
  wire       wr_clksel;
  wire       wr_t0_low;
  wire       wr_t0_high;
  wire       wr_t1_low;
  wire       wr_t1_high;

  assign wr_control = WR & (ADDR == `SPT_OFF_CONTROL);
  assign wr_mode    = WR & (ADDR == `SPT_OFF_MODE);
  assign wr_clksel  = WR & (ADDR == `SPT_OFF_CLKSEL);
  assign wr_t0_low  = WR & (ADDR == `SPT_OFF_T0_LOW);
  assign wr_t0_high = WR & (ADDR == `SPT_OFF_T0_HIGH);
  assign wr_t1_low  = WR & (ADDR == `SPT_OFF_T1_LOW);
  assign wr_t1_high = WR & (ADDR == `SPT_OFF_T1_HIGH);

  assign t0_mode           = timer_mode_reg_q[`SPT_MOD_T0_MODE_HI:`SPT_MOD_T0_MODE_LO];
  assign t1_mode           = timer_mode_reg_q[`SPT_MOD_T1_MODE_HI:`SPT_MOD_T1_MODE_LO];
  assign t0_counter_select = timer_mode_reg_q[`SPT_MOD_T0_CSEL];
  assign t0_gate_select    = timer_mode_reg_q[`SPT_MOD_T0_GATE];
  assign t1_counter_select = timer_mode_reg_q[`SPT_MOD_T1_CSEL];
  assign t1_gate_select    = timer_mode_reg_q[`SPT_MOD_T1_GATE];
  assign t0_split          = (t0_mode == `SPT_MODE_SPLIT);

  // external inputs count on a falling edge seen after synchronising
  assign t0_ext_fall = t0_pin_last_q & ~t0_pin_sync_q[1];
  assign t1_ext_fall = t1_pin_last_q & ~t1_pin_sync_q[1];

  assign pre_tick = (pre_cnt_q == PRESCALE_DIV[PRE_W-1:0] - 8'h01);

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      t0_pin_sync_q <= 2'h0;
      t1_pin_sync_q <= 2'h0;
      t0_gate_select_sync_q  <= 2'h0;
      gate1_sync_q  <= 2'h0;
      t0_pin_last_q <= 1'b0;
      t1_pin_last_q <= 1'b0;
      pre_cnt_q     <= 8'h00;
    end else if (CE) begin
      t0_pin_sync_q <= {t0_pin_sync_q[0], T0_PIN};
      t1_pin_sync_q <= {t1_pin_sync_q[0], T1_PIN};
      t0_gate_select_sync_q  <= {t0_gate_select_sync_q[0], T0_GATE_SELECT_PIN};
      gate1_sync_q  <= {gate1_sync_q[0], GATE1_PIN};
      t0_pin_last_q <= t0_pin_sync_q[1];
      t1_pin_last_q <= t1_pin_sync_q[1];
      pre_cnt_q     <= pre_tick ? 8'h00 : pre_cnt_q + 8'h01;
    end
  end

  // timer 0 control, including its split form
  always @* begin
    t0_tick = t0_counter_select ? t0_ext_fall :
              (clksel_q[`SPT_CKS_T0_LOW_PRE] ? pre_tick : 1'b1);
    t0_run  = t0_run_bit_q & (~t0_gate_select | t0_gate_select_sync_q[1]);
    t0_low_inc    = t0_run & t0_tick;
    t0_high_inc   = 1'b0;
    t0_low_top    = `SPT_TOP_FULL;
    t0_low_reload = 1'b0;
    t0_ovf        = 1'b0;
    t0h_split_ovf = 1'b0;
    case (t0_mode)
      `SPT_MODE_13BIT: begin
        t0_low_top  = `SPT_TOP_5BIT;
        t0_high_inc = t0_low_carry;
        t0_ovf      = t0_high_carry;
      end
      `SPT_MODE_16BIT: begin
        t0_high_inc = t0_low_carry;
        t0_ovf      = t0_high_carry;
      end
      `SPT_MODE_RELOAD: begin
        t0_low_reload = 1'b1;
        t0_ovf        = t0_low_carry;
      end
      `SPT_MODE_SPLIT: begin
        // two free-standing bytes; the high one is a timer owned by t1 run
        t0_ovf        = t0_low_carry;
        t0_high_inc   = t1_run_bit_q &
                        (clksel_q[`SPT_CKS_T0_HIGH_PRE] ? pre_tick : 1'b1);
        t0h_split_ovf = t0_high_carry;
      end
      default: begin
        t0_ovf = 1'b0;
      end
    endcase
  end

  // timer 1 control; split timer 0 takes over its run bit and flag
  always @* begin
    t1_tick = (t1_counter_select & ~t0_split) ? t1_ext_fall :
              (clksel_q[`SPT_CKS_T1_PRE] ? pre_tick : 1'b1);
    if (t1_mode == `SPT_MODE_SPLIT) begin
      t1_run = 1'b0;
    end else if (t0_split) begin
      t1_run = 1'b1;
    end else begin
      t1_run = t1_run_bit_q & (~t1_gate_select | gate1_sync_q[1]);
    end
    t1_low_inc    = t1_run & t1_tick;
    t1_high_inc   = 1'b0;
    t1_low_top    = `SPT_TOP_FULL;
    t1_low_reload = 1'b0;
    t1_ovf        = 1'b0;
    case (t1_mode)
      `SPT_MODE_13BIT: begin
        t1_low_top  = `SPT_TOP_5BIT;
        t1_high_inc = t1_low_carry;
        t1_ovf      = t1_high_carry;
      end
      `SPT_MODE_16BIT: begin
        t1_high_inc = t1_low_carry;
        t1_ovf      = t1_high_carry;
      end
      `SPT_MODE_RELOAD: begin
        t1_low_reload = 1'b1;
        t1_ovf        = t1_low_carry;
      end
      default: begin
        t1_ovf = 1'b0;
      end
    endcase
    t1_flag_set = t0_split ? t0h_split_ovf : t1_ovf;
  end

  spt_count_cell #(.WIDTH(8)) u_t0_low (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .ce         (CE),
    .inc        (t0_low_inc),
    .top        (t0_low_top),
    .reload_en  (t0_low_reload),
    .reload_val (t0_high_count),
    .wr_en      (wr_t0_low),
    .wr_data    (WDATA),
    .count      (t0_low_count),
    .carry      (t0_low_carry)
  );

  spt_count_cell #(.WIDTH(8)) u_t0_high (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .ce         (CE),
    .inc        (t0_high_inc),
    .top        (`SPT_TOP_FULL),
    .reload_en  (1'b0),
    .reload_val (`SPT_RST_COUNT),
    .wr_en      (wr_t0_high),
    .wr_data    (WDATA),
    .count      (t0_high_count),
    .carry      (t0_high_carry)
  );

  spt_count_cell #(.WIDTH(8)) u_t1_low (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .ce         (CE),
    .inc        (t1_low_inc),
    .top        (t1_low_top),
    .reload_en  (t1_low_reload),
    .reload_val (t1_high_count),
    .wr_en      (wr_t1_low),
    .wr_data    (WDATA),
    .count      (t1_low_count),
    .carry      (t1_low_carry)
  );

  spt_count_cell #(.WIDTH(8)) u_t1_high (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .ce         (CE),
    .inc        (t1_high_inc),
    .top        (`SPT_TOP_FULL),
    .reload_en  (1'b0),
    .reload_val (`SPT_RST_COUNT),
    .wr_en      (wr_t1_high),
    .wr_data    (WDATA),
    .count      (t1_high_count),
    .carry      (t1_high_carry)
  );

  // flags: a hardware set beats a software clear in the same cycle
  always @* begin
    t0_overflow_flag_d = t0_overflow_flag_q;
    t1_overflow_flag_d = t1_overflow_flag_q;
    if (wr_control) begin
      t0_overflow_flag_d = WDATA[`SPT_CTL_T0_FLAG];
      t1_overflow_flag_d = WDATA[`SPT_CTL_T1_FLAG];
    end
    if (t0_ovf) begin
      t0_overflow_flag_d = 1'b1;
    end
    if (t1_flag_set) begin
      t1_overflow_flag_d = 1'b1;
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      t0_run_bit_q       <= 1'b0;
      t1_run_bit_q       <= 1'b0;
      t0_overflow_flag_q <= 1'b0;
      t1_overflow_flag_q <= 1'b0;
      timer_mode_reg_q   <= `SPT_RST_MODE;
      clksel_q           <= `SPT_RST_CLKSEL;
      t1_pulse_q         <= 1'b0;
    end else if (CE) begin
      t0_overflow_flag_q <= t0_overflow_flag_d;
      t1_overflow_flag_q <= t1_overflow_flag_d;
      // overflow pulse leaves whatever the flag does
      t1_pulse_q         <= t1_ovf;
      if (wr_control) begin
        t0_run_bit_q <= WDATA[`SPT_CTL_T0_RUN];
        t1_run_bit_q <= WDATA[`SPT_CTL_T1_RUN];
      end
      if (wr_mode) begin
        timer_mode_reg_q <= WDATA;
      end
      if (wr_clksel) begin
        clksel_q <= WDATA[`SPT_CKS_USED_W-1:0];
      end
    end
  end

  // read data stand in the cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    case (ADDR)
      `SPT_OFF_CONTROL: begin
        rdata_d = {t1_overflow_flag_q, t1_run_bit_q, t0_overflow_flag_q, t0_run_bit_q, 4'h0};
      end
      `SPT_OFF_MODE: begin
        rdata_d = timer_mode_reg_q;
      end
      `SPT_OFF_CLKSEL: begin
        rdata_d = {5'h00, clksel_q};
      end
      `SPT_OFF_T0_LOW: begin
        rdata_d = t0_low_count;
      end
      `SPT_OFF_T0_HIGH: begin
        rdata_d = t0_high_count;
      end
      `SPT_OFF_T1_LOW: begin
        rdata_d = t1_low_count;
      end
      `SPT_OFF_T1_HIGH: begin
        rdata_d = t1_high_count;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= RD ? rdata_d : 8'h00;
    end
  end

  assign RDATA        = rdata_q;
  assign T0_IRQ       = t0_overflow_flag_q;
  assign T1_IRQ       = t1_overflow_flag_q;
  assign T1_OVF_PULSE = t1_pulse_q;

endmodule

/* verif/spt_timer_chk.sv */
/*
  Port assertions and covers for the split timer pair.
  Assumes one clock, synchronous active-low reset, bound to spt_timer_top.
*/
module spt_timer_chk (
  input wire       CLK_SYS,
  input wire       RST_N,
  input wire       CE,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       T0_IRQ,
  input wire       T1_IRQ,
  input wire       T1_OVF_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  rdata_idle_a: assert property (CE && !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (CE && RD && ADDR > 4'h6 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  t0_hold_a: assert property (T0_IRQ && !(CE && WR && ADDR == 4'h0) |=> T0_IRQ)
    else $error("t0 flag dropped without a write");
  t1_hold_a: assert property (T1_IRQ && !(CE && WR && ADDR == 4'h0) |=> T1_IRQ)
    else $error("t1 flag dropped without a write");
  t0_clear_a: assert property ($fell(T0_IRQ) |-> $past(WR && ADDR == 4'h0 && !WDATA[5]))
    else $error("t0 flag fell without a clearing write");
  t1_clear_a: assert property ($fell(T1_IRQ) |-> $past(WR && ADDR == 4'h0 && !WDATA[7]))
    else $error("t1 flag fell without a clearing write");
  pulse_one_a: assert property (T1_OVF_PULSE |=> !T1_OVF_PULSE)
    else $error("overflow pulse longer than one cycle");
  t1_set_a: assert property ($rose(T1_IRQ) |-> $past(CE))
    else $error("t1 flag set while frozen");
  freeze_a: assert property (!CE |=> $stable(T0_IRQ) && $stable(T1_IRQ) && $stable(RDATA))
    else $error("state moved with clock enable low");

  cover property ($rose(T1_IRQ));
  cover property ($rose(T0_IRQ));
  cover property (T1_OVF_PULSE);
  cover property (!CE);
endmodule

bind spt_timer_top spt_timer_chk u_chk (
  .CLK_SYS      (CLK_SYS),
  .RST_N        (RST_N),
  .CE           (CE),
  .ADDR         (ADDR),
  .WDATA        (WDATA),
  .WR           (WR),
  .RD           (RD),
  .RDATA        (RDATA),
  .T0_IRQ       (T0_IRQ),
  .T1_IRQ       (T1_IRQ),
  .T1_OVF_PULSE (T1_OVF_PULSE)
);

/* verif/split_timer_mode3_test.sv */
/*
  Register-driven bench for the split timer pair in mode 3.
  Assumes the defs header on the include path and a 50 MHz clock.
*/
`include "spt_timer_defs.vh"
module split_timer_mode3_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       t0_pin = 1'b0;
  logic       t1_pin = 1'b0;
  logic       t0_gate_select_pin = 1'b0;
  logic       gate1_pin = 1'b0;
  wire  [7:0] rdata;
  wire        t0_irq;
  wire        t1_irq;
  wire        t1_ovf;
  logic [7:0] v;
  logic       seen;
  int         fail_count = 0;
  int         compares = 0;
  int         cycles = 0;
  int         i;
  int         m;

  spt_timer_top #(.PRESCALE_DIV(2)) dut (
    .CLK_SYS      (clk_sys),
    .RST_N        (rst_n),
    .CE           (ce),
    .ADDR         (addr),
    .WDATA        (wdata),
    .WR           (wr),
    .RD           (rd),
    .RDATA        (rdata),
    .T0_PIN       (t0_pin),
    .T1_PIN       (t1_pin),
    .T0_GATE_SELECT_PIN    (t0_gate_select_pin),
    .GATE1_PIN    (gate1_pin),
    .T0_IRQ       (t0_irq),
    .T1_IRQ       (t1_irq),
    .T1_OVF_PULSE (t1_ovf)
  );

  always #10 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // t1 pin chatters all run long: timer 1 must never count it while split
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    t1_pin <= ~t1_pin;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
    check(v, e);
  endtask

  task automatic t0_fall(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      t0_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t0_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic wait_ovf(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      #1;
      if (t1_ovf === 1'b1)
        seen = 1'b1;
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++)
      rd_chk(i[3:0], 8'h00);
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    // high byte alone, timer 1 parked in mode 3
    wr_reg(`SPT_OFF_MODE, 8'h33);
    wr_reg(`SPT_OFF_T1_LOW, 8'h05);
    wr_reg(`SPT_OFF_T0_HIGH, 8'hFE);
    wr_reg(`SPT_OFF_T0_LOW, 8'h10);
    rd_chk(`SPT_OFF_T0_HIGH, 8'hFE);
    wr_reg(`SPT_OFF_CONTROL, 8'h40);
    // the clear lands on the wrap edge, so the hardware set must win
    wr_reg(`SPT_OFF_CONTROL, 8'h00);
    rd_chk(`SPT_OFF_T0_HIGH, 8'h00);
    rd_chk(`SPT_OFF_T0_LOW, 8'h10);
    rd_chk(`SPT_OFF_T1_LOW, 8'h05);
    rd_chk(`SPT_OFF_CONTROL, 8'h80);
    check({7'h0, t1_irq}, 8'h01);
    check({7'h0, t0_irq}, 8'h00);
    wr_reg(`SPT_OFF_CONTROL, 8'h00);
    // 11 counting edges on the halved clock
    wr_reg(`SPT_OFF_CLKSEL, 8'h04);
    wr_reg(`SPT_OFF_T0_HIGH, 8'h00);
    wr_reg(`SPT_OFF_CONTROL, 8'h40);
    repeat (20) @(posedge clk_sys);
    wr_reg(`SPT_OFF_CONTROL, 8'h00);
    rd_chk(`SPT_OFF_CONTROL, 8'h00);
    rd_chk(`SPT_OFF_T0_HIGH, 8'h0B);
    // low byte on the external pin, then gated
    wr_reg(`SPT_OFF_MODE, 8'h37);
    wr_reg(`SPT_OFF_T0_LOW, 8'hFE);
    wr_reg(`SPT_OFF_CONTROL, 8'h10);
    t0_fall(2);
    rd_chk(`SPT_OFF_T0_LOW, 8'h00);
    check({7'h0, t0_irq}, 8'h01);
    wr_reg(`SPT_OFF_MODE, 8'h3F);
    t0_fall(2);
    rd_chk(`SPT_OFF_T0_LOW, 8'h00);
    t0_gate_select_pin <= 1'b1;
    t0_fall(3);
    rd_chk(`SPT_OFF_T0_LOW, 8'h03);
    wr_reg(`SPT_OFF_CONTROL, 8'h00);
    rd_chk(`SPT_OFF_CONTROL, 8'h00);
    check({7'h0, t0_irq}, 8'h00);
    // timer 1 in modes 0..2 beside the split timer 0
    for (m = 0; m < 3; m++) begin
      wr_reg(`SPT_OFF_T1_LOW, 8'h00);
      wr_reg(`SPT_OFF_T1_HIGH, (m == 2) ? 8'h00 : 8'hFF);
      wr_reg(`SPT_OFF_MODE, {2'b01, m[1:0], 4'h3});
      // limits beat a count of the chattering pin, which is twice as slow
      wait_ovf((m == 0) ? 40 : 300);
      check({7'h0, seen}, 8'h01);
      check({7'h0, t1_irq}, 8'h00);
    end
    wr_reg(`SPT_OFF_MODE, 8'h73);
    wr_reg(`SPT_OFF_T1_LOW, 8'h1E);
    wait_ovf(300);
    check({7'h0, seen}, 8'h00);
    rd_chk(`SPT_OFF_T1_LOW, 8'h1E);
    // three enabled edges around a five-cycle freeze
    wr_reg(`SPT_OFF_CLKSEL, 8'h00);
    wr_reg(`SPT_OFF_T0_HIGH, 8'h00);
    wr_reg(`SPT_OFF_CONTROL, 8'h40);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ce <= 1'b1;
    wr_reg(`SPT_OFF_CONTROL, 8'h00);
    rd_chk(`SPT_OFF_T0_HIGH, 8'h03);
    give_verdict();
  end
endmodule
